// ### src/ums_consts.svh
`ifndef UMS_CONSTS_SVH
`define UMS_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define UMS_CTRL_OFF   8'h08
`define UMS_MCTL_OFF   8'h10
`define UMS_LINE_OFF   8'h14
`define UMS_MLS_OFF    8'h18
`define UMS_ISTAT_OFF  8'h20
`define UMS_IMASK_OFF  8'h24

// ----------------------------------------------------------------
// modem control field positions
// ----------------------------------------------------------------
`define UMS_MC_TERM    0
`define UMS_MC_SEND    1
`define UMS_MC_AUX1    2
`define UMS_MC_AUX2    3
`define UMS_MC_LOOP    4
`define UMS_MC_W       5

// ----------------------------------------------------------------
// modem line status field positions
// ----------------------------------------------------------------
`define UMS_ML_CHG     3
`define UMS_ML_CTS     4
`define UMS_ML_DSR     5
`define UMS_ML_RING    6
`define UMS_ML_CAR     7

// ----------------------------------------------------------------
// other fields and widths
// ----------------------------------------------------------------
`define UMS_LN_DAV     0
`define UMS_CT_FIFO    0
`define UMS_IRQ_CAR    0
`define UMS_IRQ_DAV    1
`define UMS_IRQ_W      2

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define UMS_MCTL_RST   5'h00
`define UMS_MLS_RST    32'h00000000
`define UMS_IRQ_RST    2'h0
`define UMS_PIN_IDLE   4'hF
`define UMS_SYNC_DEPTH 2

`endif

// ### src/ums_pkg.sv
`include "ums_consts.svh"

package ums_pkg;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic carrier_low;
    logic ring_low;
    logic set_ready_low;
    logic clear_to_send_low;
  } ums_modem_in_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ums_bus_req_t;

  // ----------------------------------------------------------------
  // module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`UMS_IRQ_W-1:0] status;
    logic [`UMS_IRQ_W-1:0] mask;
  } ums_irq_state_t;

  typedef struct packed {
    logic [`UMS_MC_W-1:0] modem_control_reg;
    logic                 fifo_mode;
    logic                 data_avail;
    logic                 carrier_change_flag;
    logic                 carrier_prev;
    logic [31:0]          rdata;
  } ums_state_t;

endpackage

// ### src/ums_sync.sv
`timescale 1ns/1ns
`include "ums_consts.svh"

module ums_sync #(
  parameter int unsigned         WIDTH = 4,
  parameter logic [WIDTH-1:0]    IDLE  = '1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // lines
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // ----------------------------------------------------------------
  // two-stage synchroniser
  // ----------------------------------------------------------------
  // resets to the idle level so no false change shows after reset
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    next_meta = din;
    next_dout = meta;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= IDLE;
      dout <= IDLE;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end

endmodule // ums_sync

// ### src/ums_irq.sv
`timescale 1ns/1ns
`include "ums_consts.svh"

module ums_irq (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  // events
  input  wire logic [`UMS_IRQ_W-1:0] event_set,
  // software side
  input  wire logic                  clr_wr,
  input  wire logic                  mask_wr,
  input  wire logic [`UMS_IRQ_W-1:0] wdata,
  output logic      [`UMS_IRQ_W-1:0] status,
  output logic      [`UMS_IRQ_W-1:0] mask,
  // interrupt
  output logic                       irq
);

  ums_pkg::ums_irq_state_t st;
  ums_pkg::ums_irq_state_t next_st;

  // ----------------------------------------------------------------
  // sticky status, write one to clear, set wins
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (clr_wr) begin
      next_st.status = st.status & ~wdata;
    end
    next_st.status = next_st.status | event_set;
    if (mask_wr) begin
      next_st.mask = wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{status: `UMS_IRQ_RST, mask: `UMS_IRQ_RST};
    end else begin
      st <= next_st;
    end
  end

  assign status = st.status;
  assign mask   = st.mask;
  assign irq    = |(st.status & st.mask);

endmodule // ums_irq

// ### src/ums_top.sv
// Function
// [R1] data-available set when buffer or FIFO holds character
// [R2] FIFO mode: data-available clears on FIFO empty
// [R3] bit 7 reads inverse of carrier input
// [R4] loopback: carrier state follows aux output two
// [R5] bit 6 reads inverse of ring input
// [R6] loopback: ring state follows aux output one
// [R7] bit 5 reads inverse of set-ready input
// [R8] loopback: set-ready state follows terminal-ready bit
// [R9] bit 4 reads inverse of clear-to-send input
// [R10] loopback: clear-to-send state follows send-request bit
// [R11] bit 3 sticky on carrier change since read
// [R12] status read clears carrier change flag
// [R13] loopback: change flag watches aux output two
// [R14] carrier low after reset sets change flag
// [R15] inputs synchronised; change beats same-cycle read
`timescale 1ns/1ns
`include "ums_consts.svh"

module ums_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  // modem input pins, active low
  input  wire logic        carrier_in_low,
  input  wire logic        ring_in_low,
  input  wire logic        set_ready_in_low,
  input  wire logic        clear_to_send_in_low,
  // modem output pins, active low
  output logic             term_ready_out_low,
  output logic             send_request_out_low,
  output logic             aux_output_one_low,
  output logic             aux_output_two_low,
  // receive path
  input  wire logic        rx_buf_full,
  input  wire logic        rx_fifo_empty,
  output logic             loopback,
  output logic             data_available,
  // interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // bus request bundle
  // ----------------------------------------------------------------
  ums_pkg::ums_bus_req_t req;

  assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic wr_ctrl;
  logic wr_mctl;
  logic wr_istat;
  logic wr_imask;
  logic rd_mls;

  assign wr_ctrl  = req.wr && hit(req.addr, `UMS_CTRL_OFF);
  assign wr_mctl  = req.wr && hit(req.addr, `UMS_MCTL_OFF);
  assign wr_istat = req.wr && hit(req.addr, `UMS_ISTAT_OFF);
  assign wr_imask = req.wr && hit(req.addr, `UMS_IMASK_OFF);
  assign rd_mls   = req.rd && hit(req.addr, `UMS_MLS_OFF);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // idle is high on every pin, so nothing looks asserted in reset
  ums_pkg::ums_modem_in_t pins_raw;
  ums_pkg::ums_modem_in_t pins_sync;

  assign pins_raw = '{
    carrier_low:       carrier_in_low,
    ring_low:          ring_in_low,
    set_ready_low:     set_ready_in_low,
    clear_to_send_low: clear_to_send_in_low
  };

  ums_sync #(
    .WIDTH (4),
    .IDLE  (`UMS_PIN_IDLE)
  ) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     (pins_raw),
    .dout    (pins_sync)
  ); // [R15]

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ums_pkg::ums_state_t st;
  ums_pkg::ums_state_t next_st;

  logic                  loop_on;
  logic                  car_state;
  logic                  ring_state;
  logic                  set_ready_state;
  logic                  clear_to_send_state;
  logic                  car_change;
  logic                  dav_rise;
  logic [31:0]           mls_word;
  logic [`UMS_IRQ_W-1:0] irq_status;
  logic [`UMS_IRQ_W-1:0] irq_mask;
  logic [`UMS_IRQ_W-1:0] irq_events;

  assign loop_on = st.modem_control_reg[`UMS_MC_LOOP];

  // ----------------------------------------------------------------
  // modem line states
  // ----------------------------------------------------------------
  always_comb begin
    if (loop_on) begin
      car_state           = st.modem_control_reg[`UMS_MC_AUX2]; // [R4]
      ring_state          = st.modem_control_reg[`UMS_MC_AUX1]; // [R6]
      set_ready_state     = st.modem_control_reg[`UMS_MC_TERM]; // [R8]
      clear_to_send_state = st.modem_control_reg[`UMS_MC_SEND]; // [R10]
    end else begin
      car_state           = ~pins_sync.carrier_low;       // [R3]
      ring_state          = ~pins_sync.ring_low;          // [R5]
      set_ready_state     = ~pins_sync.set_ready_low;     // [R7]
      clear_to_send_state = ~pins_sync.clear_to_send_low; // [R9]
    end
  end

  // carrier_prev starts deasserted, so a carrier held low through
  // reset shows up as a change once the synchroniser settles
  assign car_change = (car_state != st.carrier_prev); // [R11] [R13] [R14]

  always_comb begin
    mls_word                  = `UMS_MLS_RST;
    mls_word[`UMS_ML_CAR]     = car_state;
    mls_word[`UMS_ML_RING]    = ring_state;
    mls_word[`UMS_ML_DSR]     = set_ready_state;
    mls_word[`UMS_ML_CTS]     = clear_to_send_state;
    mls_word[`UMS_ML_CHG]     = st.carrier_change_flag;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (wr_mctl) begin
      next_st.modem_control_reg = req.wdata[`UMS_MC_W-1:0];
    end
    if (wr_ctrl) begin
      next_st.fifo_mode = req.wdata[`UMS_CT_FIFO];
    end
    if (st.fifo_mode) begin
      next_st.data_avail = ~rx_fifo_empty; // [R1] [R2]
    end else begin
      next_st.data_avail = rx_buf_full; // [R1]
    end
    next_st.carrier_prev = car_state;
    // set beats the read-side clear
    next_st.carrier_change_flag =
      car_change | (st.carrier_change_flag & ~rd_mls); // [R11] [R12] [R15]
    next_st.rdata = 32'h00000000;
    if (req.rd) begin
      case (req.addr)
        `UMS_CTRL_OFF: begin
          next_st.rdata[`UMS_CT_FIFO] = st.fifo_mode;
        end
        `UMS_MCTL_OFF: begin
          next_st.rdata[`UMS_MC_W-1:0] = st.modem_control_reg;
        end
        `UMS_LINE_OFF: begin
          next_st.rdata[`UMS_LN_DAV] = st.data_avail;
        end
        `UMS_MLS_OFF: begin
          next_st.rdata = mls_word;
        end
        `UMS_ISTAT_OFF: begin
          next_st.rdata[`UMS_IRQ_W-1:0] = irq_status;
        end
        `UMS_IMASK_OFF: begin
          next_st.rdata[`UMS_IRQ_W-1:0] = irq_mask;
        end
        default: begin
          next_st.rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{
        modem_control_reg:   `UMS_MCTL_RST,
        fifo_mode:           1'b0,
        data_avail:          1'b0,
        carrier_change_flag: 1'b0,
        carrier_prev:        1'b0,
        rdata:               32'h00000000
      };
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign dav_rise = next_st.data_avail & ~st.data_avail;

  always_comb begin
    irq_events               = `UMS_IRQ_RST;
    irq_events[`UMS_IRQ_CAR] = car_change;
    irq_events[`UMS_IRQ_DAV] = dav_rise;
  end

  ums_irq u_irq (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .event_set (irq_events),
    .clr_wr    (wr_istat),
    .mask_wr   (wr_imask),
    .wdata     (req.wdata[`UMS_IRQ_W-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // in loopback the modem outputs idle high; the bits loop inside
  assign term_ready_out_low   = loop_on | ~st.modem_control_reg[`UMS_MC_TERM];
  assign send_request_out_low = loop_on | ~st.modem_control_reg[`UMS_MC_SEND];
  assign aux_output_one_low   = loop_on | ~st.modem_control_reg[`UMS_MC_AUX1];
  assign aux_output_two_low   = loop_on | ~st.modem_control_reg[`UMS_MC_AUX2];
  assign loopback             = loop_on;
  assign data_available       = st.data_avail;
  assign rdata                = st.rdata;

endmodule // ums_top

// ### tb/ums_props.sv
`timescale 1ns/1ns
module ums_props (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [31:0] rdata,
  // modem and receive side
  input wire logic        carrier_in_low,
  input wire logic        ring_in_low,
  input wire logic        set_ready_in_low,
  input wire logic        clear_to_send_in_low,
  input wire logic        rx_buf_full,
  input wire logic        rx_fifo_empty,
  input wire logic        loopback,
  input wire logic        data_available
);
  // ----------------------------------------------------------------
  // helper mirrors
  // ----------------------------------------------------------------
  logic [4:0] mc;
  logic       fm;
  logic [8:0] src_q;
  logic [2:0] quiet;
  logic       rdn;
  logic       rdl;
  wire        rd18 = rd_stb && addr == 8'h18;
  wire  [8:0] src = {mc, carrier_in_low, ring_in_low, set_ready_in_low, clear_to_send_in_low};
  // state bits are only judged after the synchroniser has settled
  wire        ok = rd18 && quiet >= 3'h5 && src == src_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mc <= 5'h00;
      fm <= 1'b0;
      src_q <= 9'h000;
      quiet <= 3'h0;
      rdn <= 1'b0;
      rdl <= 1'b0;
    end else begin
      if (wr_stb && addr == 8'h10) mc <= wdata[4:0];
      if (wr_stb && addr == 8'h08) fm <= wdata[0];
      src_q <= src;
      quiet <= (src != src_q) ? 3'h0 : ((quiet == 3'h7) ? quiet : quiet + 3'h1);
      rdn <= ok && !mc[4];
      rdl <= ok && mc[4];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_car; rdn |-> rdata[7] == !$past(carrier_in_low); endproperty
  a_car: assert property (p_car) else $error("carrier state bit wrong");
  property p_ring; rdn |-> rdata[6] == !$past(ring_in_low); endproperty
  a_ring: assert property (p_ring) else $error("ring state bit wrong");
  property p_dsr; rdn |-> rdata[5] == !$past(set_ready_in_low); endproperty
  a_dsr: assert property (p_dsr) else $error("set-ready state bit wrong");
  property p_cts; rdn |-> rdata[4] == !$past(clear_to_send_in_low); endproperty
  a_cts: assert property (p_cts) else $error("clear-to-send state bit wrong");
  property p_loop;
    rdl |-> rdata[7:4] == {$past(mc[3]), $past(mc[2]), $past(mc[0]), $past(mc[1])};
  endproperty
  a_loop: assert property (p_loop) else $error("loopback state bits wrong");
  property p_lb; loopback == mc[4]; endproperty
  a_lb: assert property (p_lb) else $error("loopback select wrong");
  property p_chg; !mc[4] && $changed(carrier_in_low) ##1 !rd_stb [*5] ##1 rd18 |=> rdata[3]; endproperty
  a_chg: assert property (p_chg) else $error("carrier change not flagged");
  property p_chg_lb;
    $past(mc[4]) && mc[4] && $changed(mc[3]) ##1 !rd_stb [*5] ##1 rd18 |=> rdata[3];
  endproperty
  a_chg_lb: assert property (p_chg_lb) else $error("loop change not flagged");
  property p_rd_clr; rd18 ##1 (rd18 && quiet == 3'h7) |=> !rdata[3]; endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("change flag not cleared");
  property p_dav_buf; !$past(fm) |-> data_available == $past(rx_buf_full); endproperty
  a_dav_buf: assert property (p_dav_buf) else $error("data available wrong");
  property p_dav_fifo; $past(fm) |-> data_available == !$past(rx_fifo_empty); endproperty
  a_dav_fifo: assert property (p_dav_fifo) else $error("fifo data available wrong");
endmodule // ums_props

bind ums_top ums_props props_u (.ref_clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
  .carrier_in_low, .ring_in_low, .set_ready_in_low, .clear_to_send_in_low, .rx_buf_full,
  .rx_fifo_empty, .loopback, .data_available);

// ### tb/ums_modem.sv
`timescale 1ns/1ns
module ums_modem (
  // clock
  input wire logic ref_clk,
  // lines toward the uart, active low
  output logic     carrier_in_low,
  output logic     ring_in_low,
  output logic     set_ready_in_low,
  output logic     clear_to_send_in_low
);
  // a silent data set asserts nothing, so all lines idle high
  initial {carrier_in_low, ring_in_low, set_ready_in_low, clear_to_send_in_low} = 4'hF;
  // levels move just after an edge and then hold as long as the caller waits
  task automatic drive(input logic [3:0] lines);
    @(posedge ref_clk);
    {carrier_in_low, ring_in_low, set_ready_in_low, clear_to_send_in_low} <= lines;
  endtask
endmodule // ums_modem

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        rx_buf_full = 1'b0;
  logic        rx_fifo_empty = 1'b1;
  logic [31:0] rdata;
  logic        carrier_in_low, ring_in_low, set_ready_in_low, clear_to_send_in_low;
  logic        term_ready_out_low, send_request_out_low, aux_output_one_low, aux_output_two_low;
  logic        loopback, data_available, irq;
  logic        chg = 1'b0;
  logic        cs = 1'b0;
  logic [31:0] d;
  logic [3:0]  pat [7] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF, 4'h0, 4'hF};
  logic [3:0]  mcv [6] = '{4'h8, 4'h4, 4'h1, 4'h2, 4'hF, 4'h0};
  int          mismatches = 0;
  int          compares = 0;

  always #20 ref_clk = ~ref_clk;

  ums_modem modem_u (.ref_clk, .carrier_in_low, .ring_in_low, .set_ready_in_low,
    .clear_to_send_in_low);
  ums_top dut_u (.ref_clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .carrier_in_low,
    .ring_in_low, .set_ready_in_low, .clear_to_send_in_low, .term_ready_out_low,
    .send_request_out_low, .aux_output_one_low, .aux_output_two_low, .rx_buf_full,
    .rx_fifo_empty, .loopback, .data_available, .irq);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(negedge ref_clk);
    chk(rdata, exp);
  endtask
  // expected state is true polarity {carrier, ring, set-ready, clear-to-send}
  task automatic modem_line_status(input logic [3:0] st);
    if (st[3] != cs) chg = 1'b1;
    cs = st[3];
    repeat (5) @(posedge ref_clk);
    rchk(8'h18, {24'h0, st, chg, 3'h0});
    chg = 1'b0;
  endtask
  task automatic dav(input logic fe, input logic exp);
    @(posedge ref_clk);
    rx_fifo_empty <= fe;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({31'h0, data_available}, {31'h0, exp});
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rchk(8'h18, 32'h0);
    rchk(8'h30, 32'h0);
    wr(8'h18, 32'hFF);
    rchk(8'h18, 32'h0);
    foreach (pat[i]) begin
      modem_u.drive(pat[i]);
      modem_line_status(~pat[i]);
    end
    // back-to-back reads: the first sees the flag, the second must not
    modem_u.drive(4'h7);
    repeat (8) @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= 8'h18;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(rdata, 32'h88);
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(negedge ref_clk);
    chk(rdata, 32'h80);
    // read data stand for one cycle only
    @(negedge ref_clk);
    chk(rdata, 32'h0);
    cs = 1'b1;
    modem_u.drive(4'h0);
    modem_line_status(4'hF);
    foreach (mcv[i]) begin
      wr(8'h10, {27'h0, 1'b1, mcv[i]});
      modem_line_status({mcv[i][3], mcv[i][2], mcv[i][0], mcv[i][1]});
      chk({27'h0, aux_output_two_low, aux_output_one_low, send_request_out_low,
        term_ready_out_low, loopback}, 32'h1F);
    end
    wr(8'h10, 32'h05);
    modem_line_status(4'hF);
    chk({27'h0, aux_output_two_low, aux_output_one_low, send_request_out_low,
      term_ready_out_low, loopback}, 32'h14);
    rchk(8'h10, 32'h05);
    // a carrier change on the edge that takes a status read keeps the flag
    wr(8'h10, 32'h10);
    rd_stb <= 1'b1;
    addr <= 8'h18;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(negedge ref_clk);
    chk(rdata, 32'h00);
    rchk(8'h18, 32'h08);
    // carrier held low across a reset must come back flagged
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    cs = 1'b0;
    modem_line_status(4'hF);
    rchk(8'h20, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(8'h24, 32'h3);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    rchk(8'h24, 32'h3);
    wr(8'h20, 32'h1);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    @(posedge ref_clk);
    rx_buf_full <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rchk(8'h14, 32'h1);
    rchk(8'h20, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(8'h08, 32'h1);
    rchk(8'h08, 32'h1);
    dav(1'b1, 1'b0);
    dav(1'b0, 1'b1);
    dav(1'b1, 1'b0);
    tally_and_finish();
  end
endmodule // tb_top
